// File: inc/port_irq_regs.svh
// Purpose: Offsets, field positions, reset values and counts for port irq.
// Assumes: 8-bit register port, byte offsets as printed.
// Notes: Definitions only.
`ifndef PORT_IRQ_REGS_SVH
`define PORT_IRQ_REGS_SVH
`define OFS_KEYSCAN_DATA 8'h00
`define OFS_PORT_MISC_CONTROL 8'h3a
`define OFS_EXTERNAL_REQUEST_FLAGS 8'h3b
`define OFS_IRQ_STATUS 8'h3c
`define OFS_IRQ_MASK 8'h3d
`define OFS_KEYSCAN_CTRL 8'h3e
`define RST_PORT_MISC_CONTROL 8'h80
`define BIT_DEBOUNCE_ENABLE 6
`define BIT_EDGE_POLARITY_SELECT 5
`define BIT_KEYSCAN_IRQ_FLAG 0
`define BIT_KEYSCAN_IRQ_ENABLE 1
`define DEBOUNCE_LF_CYCLES 512
`endif

// File: inc/port_irq_pkg.sv
// Purpose: Types shared by the port interrupt logic.
// Assumes: Nothing beyond the register header.
// Notes: Debounce state enumeration.
package port_irq_pkg;
  typedef enum logic [1:0] {DB_IDLE, DB_COUNT, DB_DONE} debounce_state_t;
endpackage : port_irq_pkg

// File: core/lf_edge_sync.sv
// Purpose: Two-flop synchroniser of the low-frequency clock with rise pulse.
// Assumes: LF clock much slower than CLOCK.
// Notes: First flop is read only by the second.
`timescale 1ns/1ns
module lf_edge_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lf_in,
  output logic rise_pulse
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // Synchronise then detect a rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= lf_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign rise_pulse = sync_reg & ~last_reg;
endmodule : lf_edge_sync

// File: core/port_transition_and_edge_irq.sv
// Purpose: Keyboard-port transition interrupt and three edge interrupts.
// Assumes: Pins synchronous to CLOCK; LF oscillator sampled internally.
// Notes: Register port gives read data one cycle after the read strobe.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`include "port_irq_regs.svh"

// Function
// [R1] Keyscan irq requested when port differs from latched reference.
// [R2] Each read of keyscan data latches the pins as new reference.
// [R3] Software inputs, reads, clears flag, enables, unmasks, rereads in ISR.
// [R4] Control bit 6 enables the debounce filter, zero bypasses it.
// [R5] Debounce starts only after the first transition is seen.
// [R6] Debounce needs 512 stable low-frequency clock cycles.
// [R7] With debounce, interrupt only after data settles stable.
// [R8] Port E bits 0 to 2 are three edge interrupt sources.
// [R9] Software sets those pins input and function bits to one first.
// [R10] Control bit 5 selects rising (1) or falling (0) edges.
// [R11] Request register bits 2..0 read one for occurred interrupts.
// [R12] Writing one clears a request bit, zero leaves it alone.
// [R13] Keyscan flag is sticky; forwarded only while its enable is set. IRQ still takes keyscan events via status bit 0 regardless of it.
module port_transition_and_edge_irq #(
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_LF_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [7:0] KEYSCAN_PORT_DATA,
  input wire logic [2:0] EDGE_IRQ_PINS,
  input wire logic LOW_FREQ_OSCILLATOR,
  output logic [2:0] PIN_FUNCTION_ENABLE,
  output logic PULL_ENABLE,
  output logic [1:0] CHIP_SELECT_MODE,
  output logic KEYSCAN_IRQ,
  output logic IRQ
);
  // Refuse counts that the 16-bit stability counter cannot serve
  if (DEBOUNCE_CYCLES < 2 || DEBOUNCE_CYCLES > 65535) begin : g_bad_count
    $error("DEBOUNCE_CYCLES out of range");
  end

  localparam logic [15:0] DB_LAST = 16'(DEBOUNCE_CYCLES - 1);

  logic [7:0] misc_reg;
  logic [7:0] reference_reg;
  logic [7:0] filtered_reg;
  logic [2:0] edge_prev_reg;
  logic [2:0] ext_req_reg;
  logic [1:0] ks_ctrl_reg;
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic [15:0] db_count_reg;
  logic [7:0] rdata_reg;
  port_irq_pkg::debounce_state_t db_state_reg;
  port_irq_pkg::debounce_state_t db_state_next;

  logic lf_tick;
  lf_edge_sync u_lf_sync (
    .clk(CLOCK),
    .rst_n(RST_N),
    .lf_in(LOW_FREQ_OSCILLATOR),
    .rise_pulse(lf_tick)
  );

  // Address decode
  wire sel_data = (ADDR == `OFS_KEYSCAN_DATA);
  wire sel_misc = (ADDR == `OFS_PORT_MISC_CONTROL);
  wire sel_external_request_flags = (ADDR == `OFS_EXTERNAL_REQUEST_FLAGS);
  wire sel_stat = (ADDR == `OFS_IRQ_STATUS);
  wire sel_mask = (ADDR == `OFS_IRQ_MASK);
  wire sel_kctl = (ADDR == `OFS_KEYSCAN_CTRL);
  wire ref_capture = RD & sel_data; // R2
  wire wr_misc = WR & sel_misc;
  wire wr_external_request_flags = WR & sel_external_request_flags;
  wire wr_kctl = WR & sel_kctl;
  wire wr_mask = WR & sel_mask;
  wire rd_stat = RD & sel_stat;

  // Control fields
  wire debounce_enable = misc_reg[`BIT_DEBOUNCE_ENABLE]; // R4
  wire edge_polarity_select = misc_reg[`BIT_EDGE_POLARITY_SELECT];
  assign PIN_FUNCTION_ENABLE = misc_reg[2:0];
  assign PULL_ENABLE = misc_reg[7];
  assign CHIP_SELECT_MODE = misc_reg[4:3];

  // Transition compare, raw and after debounce
  wire raw_diff = (KEYSCAN_PORT_DATA != reference_reg); // R1
  wire port_moved = (KEYSCAN_PORT_DATA != filtered_reg);
  wire db_settled = (db_state_reg == port_irq_pkg::DB_COUNT) & lf_tick &
    (db_count_reg == DB_LAST) & ~port_moved; // R6
  wire filt_diff = db_settled & (KEYSCAN_PORT_DATA != reference_reg); // R7
  wire ks_event = debounce_enable ? filt_diff : raw_diff; // R4

  // Edge detection, polarity per control bit
  wire [2:0] rise = EDGE_IRQ_PINS & ~edge_prev_reg;
  wire [2:0] fall = ~EDGE_IRQ_PINS & edge_prev_reg;
  wire [2:0] edge_hit = edge_polarity_select ? rise : fall; // R10

  // Debounce sequencer: idle until first transition
  always_comb begin
    db_state_next = db_state_reg;
    case (db_state_reg)
      port_irq_pkg::DB_IDLE: begin
        if (debounce_enable && raw_diff) begin
          db_state_next = port_irq_pkg::DB_COUNT; // R5
        end
      end
      port_irq_pkg::DB_COUNT: begin
        if (!debounce_enable) begin
          db_state_next = port_irq_pkg::DB_IDLE;
        end else if (db_settled) begin
          db_state_next = port_irq_pkg::DB_DONE;
        end
      end
      port_irq_pkg::DB_DONE: begin
        if (!debounce_enable || ref_capture) begin
          db_state_next = port_irq_pkg::DB_IDLE;
        end
      end
      default: db_state_next = port_irq_pkg::DB_IDLE;
    endcase
  end

  // Debounce state, stability counter and filtered copy
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      db_state_reg <= port_irq_pkg::DB_IDLE;
      db_count_reg <= 16'h0000;
      filtered_reg <= 8'h00;
    end else begin
      db_state_reg <= db_state_next;
      // Leaving the count state clears the counter, so idle starts at zero
      if (db_state_reg != port_irq_pkg::DB_COUNT ||
        db_state_next != port_irq_pkg::DB_COUNT || port_moved) begin
        db_count_reg <= 16'h0000; // R6
        filtered_reg <= KEYSCAN_PORT_DATA;
      end else if (lf_tick) begin
        db_count_reg <= db_count_reg + 16'h0001;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      misc_reg <= `RST_PORT_MISC_CONTROL;
      mask_reg <= 2'b00;
      reference_reg <= 8'h00;
      edge_prev_reg <= 3'b000;
    end else begin
      if (wr_misc) misc_reg <= WDATA;
      if (wr_mask) mask_reg <= WDATA[1:0];
      if (ref_capture) reference_reg <= KEYSCAN_PORT_DATA; // R2
      edge_prev_reg <= EDGE_IRQ_PINS; // R8
    end
  end

  // Sticky request flags; a new event beats a same-cycle clear
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ext_req_reg <= 3'b000;
      ks_ctrl_reg <= 2'b00;
    end else begin
      ext_req_reg <= (ext_req_reg & ~({3{wr_external_request_flags}} & WDATA[2:0]))
        | edge_hit; // R12
      ks_ctrl_reg[`BIT_KEYSCAN_IRQ_ENABLE] <= wr_kctl ?
        WDATA[`BIT_KEYSCAN_IRQ_ENABLE] :
        ks_ctrl_reg[`BIT_KEYSCAN_IRQ_ENABLE];
      ks_ctrl_reg[`BIT_KEYSCAN_IRQ_FLAG] <= ks_event |
        (ks_ctrl_reg[`BIT_KEYSCAN_IRQ_FLAG] &
        ~(wr_kctl & WDATA[`BIT_KEYSCAN_IRQ_FLAG])); // R13
    end
  end

  // Summary status: bit0 keyscan, bit1 any external; read clears
  wire [1:0] stat_set = {|edge_hit, ks_event};
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      status_reg <= 2'b00;
    end else begin
      status_reg <= (rd_stat ? 2'b00 : status_reg) | stat_set;
    end
  end

  // Read mux, data one cycle after the strobe
  wire [7:0] rd_mux =
    sel_data ? KEYSCAN_PORT_DATA :
    sel_misc ? misc_reg :
    sel_external_request_flags ? {5'b00000, ext_req_reg} : // R11
    sel_stat ? {6'b000000, status_reg} :
    sel_mask ? {6'b000000, mask_reg} :
    sel_kctl ? {6'b000000, ks_ctrl_reg} : 8'h00;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= RD ? rd_mux : 8'h00;
    end
  end
  assign RDATA = rdata_reg;

  // Interrupt outputs
  assign KEYSCAN_IRQ = ks_ctrl_reg[`BIT_KEYSCAN_IRQ_FLAG] &
    ks_ctrl_reg[`BIT_KEYSCAN_IRQ_ENABLE]; // R13
  assign IRQ = |(status_reg & mask_reg);

  // Assertions
  a_edge_sets_req: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (edge_polarity_select && $rose(EDGE_IRQ_PINS[0])) |=>
    ext_req_reg[0]) else $error("rising edge lost"); // R10
  a_fall_sets_req: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (!edge_polarity_select && $fell(EDGE_IRQ_PINS[1])) |=>
    ext_req_reg[1]) else $error("falling edge lost"); // R8
  a_clear_req: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (wr_external_request_flags && WDATA[2] && edge_hit[2] == 1'b0) |=> !ext_req_reg[2])
    else $error("request not cleared"); // R12
  a_zero_keeps: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (wr_external_request_flags && !WDATA[0] && ext_req_reg[0]) |=> ext_req_reg[0])
    else $error("zero write cleared"); // R12
  a_external_request_flags_read: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (RD && sel_external_request_flags) |=> RDATA == {5'b00000, $past(ext_req_reg)})
    else $error("request readback wrong"); // R11
  a_ref_latch: assert property (@(posedge CLOCK) disable iff (!RST_N)
    ref_capture |=> reference_reg == $past(KEYSCAN_PORT_DATA))
    else $error("reference not latched"); // R2
  a_raw_flag: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (!debounce_enable && raw_diff) |=> ks_ctrl_reg[0])
    else $error("transition flag missing"); // R1
  a_db_idle: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (db_state_reg == port_irq_pkg::DB_IDLE) |-> db_count_reg == 16'h0000)
    else $error("debounce ran early"); // R5
  a_db_hold: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (debounce_enable && !ks_ctrl_reg[0] && !db_settled &&
    !(wr_kctl && WDATA[0])) |=> !ks_ctrl_reg[0])
    else $error("unsettled irq"); // R7
  a_db_count: assert property (@(posedge CLOCK) disable iff (!RST_N) // R6
    db_count_reg <= DB_LAST)
    else $error("settle count overran");
  a_ks_gate: assert property (@(posedge CLOCK) disable iff (!RST_N) // R13
    (wr_kctl && !WDATA[1]) |=> !KEYSCAN_IRQ)
    else $error("ungated keyscan irq");
  // Read data stand only in the cycle after a read strobe
  a_rdata_idle: assert property (@(posedge CLOCK) disable iff (!RST_N) // R11
    !RD |=> RDATA == 8'h00)
    else $error("read data outside read cycle");
  // Keyscan flag holds until software clears it
  a_ks_sticky: assert property (@(posedge CLOCK) disable iff (!RST_N) // R13
    (ks_ctrl_reg[0] && !(wr_kctl && WDATA[0])) |=> ks_ctrl_reg[0])
    else $error("keyscan flag dropped");
  // Status read clears when no event lands at once
  a_stat_clear: assert property (@(posedge CLOCK) disable iff (!RST_N) // R13
    (rd_stat && stat_set == 2'b00) |=> status_reg == 2'b00)
    else $error("status not cleared");
  // A port change while counting restarts the stability count
  a_port_restart: assert property (@(posedge CLOCK) disable iff (!RST_N) // R6
    (db_state_reg == port_irq_pkg::DB_COUNT && port_moved) |=>
    db_count_reg == 16'h0000)
    else $error("count not restarted");
  // Settled data that differs from the reference raises the flag
  a_settle_flag: assert property (@(posedge CLOCK) disable iff (!RST_N) // R7
    (debounce_enable && db_settled &&
    KEYSCAN_PORT_DATA != reference_reg) |=> ks_ctrl_reg[0])
    else $error("settled change lost");
  // First transition starts the filter
  a_db_start: assert property (@(posedge CLOCK) disable iff (!RST_N) // R5
    (db_state_reg == port_irq_pkg::DB_IDLE && debounce_enable &&
    raw_diff) |=> db_state_reg == port_irq_pkg::DB_COUNT)
    else $error("filter did not start");
  // Rising polarity ignores falling edges
  a_no_fall_req: assert property (@(posedge CLOCK) disable iff (!RST_N) // R10
    (edge_polarity_select && !$rose(EDGE_IRQ_PINS[2]) &&
    !ext_req_reg[2]) |=> !ext_req_reg[2])
    else $error("wrong edge set request");
  a_dbn_bit: assert property (@(posedge CLOCK) disable iff (!RST_N)
    wr_misc |=> debounce_enable == $past(WDATA[6]))
    else $error("debounce bit wrong"); // R4
endmodule : port_transition_and_edge_irq

// File: tb/pin_side_model.sv
// Purpose: Model of the pins around the block: key return lines, edge pins.
// Assumes: Pins change one cycle after the bench asks, synchronous to clk.
// Notes: The low-frequency oscillator free-runs at clk/16.
`timescale 1ns/1ns
module pin_side_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] key_req,
  input wire logic [2:0] edge_req,
  output logic [7:0] keys,
  output logic [2:0] edges,
  output logic lf_clk
);
  logic [2:0] div_reg;

  // Pin levels follow the bench; the oscillator divides clk freely
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      keys <= 8'h00;
      edges <= 3'h0;
      div_reg <= 3'h0;
      lf_clk <= 1'b0;
    end else begin
      keys <= key_req;
      edges <= edge_req;
      div_reg <= div_reg + 3'h1;
      if (div_reg == 3'h7) begin
        lf_clk <= ~lf_clk;
      end
    end
  end
endmodule : pin_side_model

// File: tb/port_transition_and_edge_irq_tb_top.sv
// Purpose: Self-checking bench for the port transition and edge irq block.
// Assumes: Debounce count shortened to 4 low-frequency cycles.
// Notes: Registers are reached through the plain strobe port.
`timescale 1ns/1ns
`include "port_irq_regs.svh"
module port_transition_and_edge_irq_tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [7:0] key_req = 8'h00;
  logic [2:0] edge_req = 3'h0;
  logic [7:0] keys;
  logic [2:0] edges;
  logic lf_clk;
  logic [2:0] pin_fn;
  logic pull_en;
  logic [1:0] cs_mode;
  logic keyscan_irq;
  logic irq;
  int bad_count = 0;
  int n_compared = 0;

  // Free-running 100 MHz clock
  always #5 clock = ~clock;

  pin_side_model u_pins (.clk(clock), .rst_n(rst_n), .key_req(key_req),
    .edge_req(edge_req), .keys(keys), .edges(edges), .lf_clk(lf_clk));

  port_transition_and_edge_irq #(.DEBOUNCE_CYCLES(4)) u_dut (
    .CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .KEYSCAN_PORT_DATA(keys),
    .EDGE_IRQ_PINS(edges), .LOW_FREQ_OSCILLATOR(lf_clk),
    .PIN_FUNCTION_ENABLE(pin_fn), .PULL_ENABLE(pull_en),
    .CHIP_SELECT_MODE(cs_mode),
    .KEYSCAN_IRQ(keyscan_irq), .IRQ(irq));

  task automatic close_out;
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd_reg

  // Move the pins, then let the events land before sampling
  task automatic pins(input logic [7:0] k, input logic [2:0] e, input int n);
    @(posedge clock);
    key_req <= k;
    edge_req <= e;
    repeat (n) @(posedge clock);
    #1;
  endtask : pins

  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd_reg(`OFS_PORT_MISC_CONTROL, 8'h80);
    rd_reg(`OFS_EXTERNAL_REQUEST_FLAGS, 8'h00);
    rd_reg(8'h55, 8'h00);
    chk({2'b00, pull_en, cs_mode, pin_fn}, 8'h20);
    wr_reg(`OFS_PORT_MISC_CONTROL, 8'h18);
    #1;
    chk({2'b00, pull_en, cs_mode, pin_fn}, 8'h18);
    wr_reg(`OFS_PORT_MISC_CONTROL, 8'ha7);
    rd_reg(`OFS_PORT_MISC_CONTROL, 8'ha7);
    chk({2'b00, pull_en, cs_mode, pin_fn}, 8'h27);
    wr_reg(`OFS_IRQ_MASK, 8'h02);
    pins(8'h00, 3'h7, 5);
    chk({7'h00, irq}, 8'h01);
    rd_reg(`OFS_EXTERNAL_REQUEST_FLAGS, 8'h07);
    wr_reg(`OFS_EXTERNAL_REQUEST_FLAGS, 8'h02);
    rd_reg(`OFS_EXTERNAL_REQUEST_FLAGS, 8'h05);
    rd_reg(`OFS_IRQ_STATUS, 8'h02);
    #1;
    chk({7'h00, irq}, 8'h00);
    wr_reg(`OFS_EXTERNAL_REQUEST_FLAGS, 8'h07);
    rd_reg(`OFS_EXTERNAL_REQUEST_FLAGS, 8'h00);
    wr_reg(`OFS_PORT_MISC_CONTROL, 8'h87);
    pins(8'h00, 3'h0, 5);
    rd_reg(`OFS_EXTERNAL_REQUEST_FLAGS, 8'h07);
    wr_reg(`OFS_EXTERNAL_REQUEST_FLAGS, 8'h07);
    pins(8'h00, 3'h5, 5);
    rd_reg(`OFS_EXTERNAL_REQUEST_FLAGS, 8'h00);
    wr_reg(`OFS_IRQ_MASK, 8'h00);
    #1;
    chk({7'h00, irq}, 8'h00);
    rd_reg(`OFS_IRQ_STATUS, 8'h02);
    // Keyscan transition without the filter
    rd_reg(`OFS_KEYSCAN_DATA, 8'h00);
    wr_reg(`OFS_KEYSCAN_CTRL, 8'h03);
    pins(8'h5a, 3'h5, 5);
    chk({7'h00, keyscan_irq}, 8'h01);
    rd_reg(`OFS_KEYSCAN_DATA, 8'h5a);
    wr_reg(`OFS_KEYSCAN_CTRL, 8'h03);
    pins(8'h5a, 3'h5, 5);
    chk({7'h00, keyscan_irq}, 8'h00);
    rd_reg(`OFS_KEYSCAN_CTRL, 8'h02);
    wr_reg(`OFS_KEYSCAN_CTRL, 8'h01);
    pins(8'h00, 3'h5, 5);
    chk({7'h00, keyscan_irq}, 8'h00);
    rd_reg(`OFS_KEYSCAN_CTRL, 8'h01);
    wr_reg(`OFS_IRQ_MASK, 8'h01);
    #1;
    chk({7'h00, irq}, 8'h01);
    rd_reg(`OFS_IRQ_STATUS, 8'h01);
    // Keyscan transition through the filter
    wr_reg(`OFS_PORT_MISC_CONTROL, 8'hc7);
    rd_reg(`OFS_KEYSCAN_DATA, 8'h00);
    wr_reg(`OFS_KEYSCAN_CTRL, 8'h03);
    pins(8'h11, 3'h5, 40);
    chk({7'h00, keyscan_irq}, 8'h00);
    for (int i = 0; i < 150 && keyscan_irq !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    chk({7'h00, keyscan_irq}, 8'h01);
    close_out();
  end

  // Watchdog cuts a hang short
  initial begin
    #50000;
    bad_count++;
    close_out();
  end
endmodule : port_transition_and_edge_irq_tb_top
